// File: timer_pkg.sv
package timer_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_COUNT_LOW_ZERO = 8'h8a;
    localparam logic [7:0] ADDR_COUNT_LOW_ONE = 8'h8b;
    localparam logic [7:0] ADDR_COUNT_HIGH_ZERO = 8'h8c;
    localparam logic [7:0] ADDR_COUNT_HIGH_ONE = 8'h8d;
    localparam logic [7:0] ADDR_EXTENDED_TIMER_MODE = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW_ZERO = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_LOW_ONE = 8'h93;
    localparam logic [7:0] ADDR_RELOAD_HIGH_ZERO = 8'h94;
    localparam logic [7:0] ADDR_RELOAD_HIGH_ONE = 8'h95;

    // timer_control bit positions, per timer t: run at RUN_BIT0 + 2t, flag at FLAG_BIT0 + 2t
    localparam int RUN_BIT0 = 4;
    localparam int FLAG_BIT0 = 5;
    localparam int CTRL_STRIDE = 2;

    // timer_mode fields, per timer t at offset TIMER_MODE_STRIDE * t
    localparam int TIMER_MODE_STRIDE = 4;
    localparam int MODE_LSB = 0;
    localparam int FUNC_BIT = 2;
    localparam int GATE_BIT = 3;

    // extended_timer_mode: prescale width field of timer t at PSC_STRIDE * t
    localparam int PSC_STRIDE = 3;
    localparam int PSC_WIDTH = 3;

    // reset values
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
    localparam logic [7:0] EXTENDED_MODE_RESET = 8'h24;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;

    // shared clock prescaler width (divide by 1 to 16)
    localparam int TPS_WIDTH = 4;

    typedef enum logic [1:0] {
        MODE_VARIABLE,
        MODE_RELOAD16,
        MODE_RELOAD8,
        MODE_STOPPED
    } timer_mode_e;

endpackage

// File: dual_reload_timer_counter.sv
`timescale 1ns/10ps
// How it works
// - timer function advances once per (prescaled) system clock cycle
// - one shared prescaler divides the timer rate by 1 to 16
// - counter function counts when a high sample is followed by a low one
// - the edge-driven increment shows in the count the cycle after detection
// - edge detection needs two cycles, so count rate is at most half clock
// - per timer, mode register holds function-select bit and two-bit mode field
// - mode 0: 8-bit counter behind a 1 to 8 bit prescaler
// - mode 0 default is 13 bits: high byte plus low five bits
// - mode 0 rollover from all ones to zero sets the overflow flag
// - counting only while run bit set and gate clear or gate pin high
// - setting a run bit leaves the count registers untouched
// - pin-qualify bits sit at mode bit 7 (timer one) and bit 3
// - timer zero behaves like timer one with its own bits and pins
// - mode 1: 16-bit up count, reload and flag on FFFF to 0000
// - reload registers reset to zero for the full 16-bit period
// - mode 2: low byte overflow sets flag, reloads low from high byte
// - mode 0 period is 256 * 2^(width+1) * (prescale+1) clocks
// - mode 1 period is (65536 - reload) * (prescale+1) clocks
// - mode 2 period is (256 - high byte) * (prescale+1) clocks
// - in modes 0 and 2 reload registers are plain storage
// - function-select clear picks system clock, set picks count pin
// - overflow flag set by hardware, cleared on interrupt vectoring
// - mode field 00, 01, 10 pick modes 0 to 2; 11 stops the timer
module dual_reload_timer_counter
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [TPS_WIDTH-1:0] clock_prescale_value,
    input wire logic int_ack_zero,
    input wire logic int_ack_one,
    input wire logic count_input_pin_zero,
    input wire logic count_input_pin_one,
    input wire logic ext_interrupt_pin_zero,
    input wire logic ext_interrupt_pin_one,
    output logic [7:0] sfr_rdata,
    output logic overflow_flag_zero,
    output logic overflow_flag_one
);

    typedef struct packed {
        logic [TPS_WIDTH-1:0] presc_cnt;
        logic [1:0] run;
        logic [1:0] flag;
        logic [7:0] timer_mode;
        logic [7:0] ext_mode;
        logic [1:0][7:0] cnt_lo;
        logic [1:0][7:0] cnt_hi;
        logic [1:0][7:0] rel_lo;
        logic [1:0][7:0] rel_hi;
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
        logic [1:0] pin_prev;
        logic [1:0] gate_meta;
        logic [1:0] gate_sync;
        logic [7:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic tick;
    logic [1:0] edge_seen;
    logic [1:0] step;
    logic [1:0] ovf;
    logic [1:0] ack;

    assign ack = {int_ack_one, int_ack_zero};
    // shared prescaler pulse: one cycle in every prescale+1
    assign tick = (state_reg.presc_cnt == clock_prescale_value);
    // a sample high followed by a sample low, both past the synchroniser
    assign edge_seen = state_reg.pin_prev & ~state_reg.pin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        timer_mode_e mode;
        logic func;
        logic gate;
        logic pulse;
        logic [PSC_WIDTH-1:0] prescale_width_field;
        logic [7:0] mask;
        logic [7:0] lo_inc;
        logic [15:0] full;
        mode = MODE_VARIABLE;
        func = 1'b0;
        gate = 1'b0;
        pulse = 1'b0;
        prescale_width_field = '0;
        mask = '0;
        lo_inc = '0;
        full = '0;
        state_next = state_reg;
        step = '0;
        ovf = '0;

        // pins are asynchronous: two flops, then a third stage for the edge
        state_next.pin_meta = {count_input_pin_one, count_input_pin_zero};
        state_next.pin_sync = state_reg.pin_meta;
        state_next.pin_prev = state_reg.pin_sync;
        state_next.gate_meta = {ext_interrupt_pin_one, ext_interrupt_pin_zero};
        state_next.gate_sync = state_reg.gate_meta;

        // prescaler restarts after each pulse
        if (tick) begin
            state_next.presc_cnt = '0;
        end else begin
            state_next.presc_cnt = state_reg.presc_cnt + 1'b1;
        end

        // both timers share one body; timer zero mirrors timer one
        for (int t = 0; t < 2; t++) begin
            mode = timer_mode_e'(state_reg.timer_mode[t*TIMER_MODE_STRIDE+MODE_LSB +: 2]);
            func = state_reg.timer_mode[t*TIMER_MODE_STRIDE+FUNC_BIT];
            gate = state_reg.timer_mode[t*TIMER_MODE_STRIDE+GATE_BIT];
            prescale_width_field = state_reg.ext_mode[t*PSC_STRIDE +: PSC_WIDTH];
            pulse = func ? edge_seen[t] : tick;
            step[t] = pulse && state_reg.run[t]
                && (!gate || state_reg.gate_sync[t])
                && (mode != MODE_STOPPED);
            if (step[t]) begin
                case (mode)
                    MODE_VARIABLE: begin
                        // low byte acts as a prescaler of psc+1 bits
                        mask = 8'hff >> (3'd7 - prescale_width_field);
                        lo_inc = state_reg.cnt_lo[t] + 8'h01;
                        if ((state_reg.cnt_lo[t] & mask) == mask) begin
                            state_next.cnt_lo[t] = state_reg.cnt_lo[t] & ~mask;
                            state_next.cnt_hi[t] = state_reg.cnt_hi[t] + 8'h01;
                            ovf[t] = (state_reg.cnt_hi[t] == 8'hff);
                        end else begin
                            // upper low bits hold whatever was there
                            state_next.cnt_lo[t] = (state_reg.cnt_lo[t] & ~mask)
                                | (lo_inc & mask);
                        end
                    end
                    MODE_RELOAD16: begin
                        full = {state_reg.cnt_hi[t], state_reg.cnt_lo[t]};
                        if (full == 16'hffff) begin
                            state_next.cnt_hi[t] = state_reg.rel_hi[t];
                            state_next.cnt_lo[t] = state_reg.rel_lo[t];
                            ovf[t] = 1'b1;
                        end else begin
                            full = full + 16'h0001;
                            state_next.cnt_hi[t] = full[15:8];
                            state_next.cnt_lo[t] = full[7:0];
                        end
                    end
                    MODE_RELOAD8: begin
                        if (state_reg.cnt_lo[t] == 8'hff) begin
                            state_next.cnt_lo[t] = state_reg.cnt_hi[t];
                            ovf[t] = 1'b1;
                        end else begin
                            state_next.cnt_lo[t] = state_reg.cnt_lo[t] + 8'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // acknowledge clears, overflow sets; set wins
            state_next.flag[t] = (state_reg.flag[t] & ~ack[t]) | ovf[t];
        end

        // software writes to a count byte override a same-cycle count step; an overflow still sets the flag
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_TIMER_CONTROL: begin
                    for (int t = 0; t < 2; t++) begin
                        // run and flag bits only; counts stay as they are
                        state_next.run[t] = sfr_wdata[RUN_BIT0+t*CTRL_STRIDE];
                        state_next.flag[t] = sfr_wdata[FLAG_BIT0+t*CTRL_STRIDE] | ovf[t];
                    end
                end
                ADDR_TIMER_MODE: state_next.timer_mode = sfr_wdata;
                ADDR_EXTENDED_TIMER_MODE: state_next.ext_mode = sfr_wdata;
                ADDR_COUNT_LOW_ZERO: state_next.cnt_lo[0] = sfr_wdata;
                ADDR_COUNT_LOW_ONE: state_next.cnt_lo[1] = sfr_wdata;
                ADDR_COUNT_HIGH_ZERO: state_next.cnt_hi[0] = sfr_wdata;
                ADDR_COUNT_HIGH_ONE: state_next.cnt_hi[1] = sfr_wdata;
                // reload bytes are plain storage outside mode 1
                ADDR_RELOAD_LOW_ZERO: state_next.rel_lo[0] = sfr_wdata;
                ADDR_RELOAD_LOW_ONE: state_next.rel_lo[1] = sfr_wdata;
                ADDR_RELOAD_HIGH_ZERO: state_next.rel_hi[0] = sfr_wdata;
                ADDR_RELOAD_HIGH_ONE: state_next.rel_hi[1] = sfr_wdata;
                default: begin
                end
            endcase
        end

        // read data is registered; external interrupt bits of control read zero
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_TIMER_CONTROL: begin
                    state_next.rdata = 8'h00;
                    for (int t = 0; t < 2; t++) begin
                        state_next.rdata[RUN_BIT0+t*CTRL_STRIDE] = state_reg.run[t];
                        state_next.rdata[FLAG_BIT0+t*CTRL_STRIDE] = state_reg.flag[t];
                    end
                end
                ADDR_TIMER_MODE: state_next.rdata = state_reg.timer_mode;
                ADDR_EXTENDED_TIMER_MODE: state_next.rdata = state_reg.ext_mode;
                ADDR_COUNT_LOW_ZERO: state_next.rdata = state_reg.cnt_lo[0];
                ADDR_COUNT_LOW_ONE: state_next.rdata = state_reg.cnt_lo[1];
                ADDR_COUNT_HIGH_ZERO: state_next.rdata = state_reg.cnt_hi[0];
                ADDR_COUNT_HIGH_ONE: state_next.rdata = state_reg.cnt_hi[1];
                ADDR_RELOAD_LOW_ZERO: state_next.rdata = state_reg.rel_lo[0];
                ADDR_RELOAD_LOW_ONE: state_next.rdata = state_reg.rel_lo[1];
                ADDR_RELOAD_HIGH_ZERO: state_next.rdata = state_reg.rel_hi[0];
                ADDR_RELOAD_HIGH_ONE: state_next.rdata = state_reg.rel_hi[1];
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
            state_reg.run <= {TIMER_CONTROL_RESET[RUN_BIT0+CTRL_STRIDE],
                TIMER_CONTROL_RESET[RUN_BIT0]};
            state_reg.flag <= {TIMER_CONTROL_RESET[FLAG_BIT0+CTRL_STRIDE],
                TIMER_CONTROL_RESET[FLAG_BIT0]};
            state_reg.timer_mode <= TIMER_MODE_RESET;
            state_reg.ext_mode <= EXTENDED_MODE_RESET; // 13-bit mode 0 by default
            state_reg.cnt_lo <= {2{COUNT_RESET}};
            state_reg.cnt_hi <= {2{COUNT_RESET}};
            state_reg.rel_lo <= {2{RELOAD_RESET}};
            state_reg.rel_hi <= {2{RELOAD_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata = state_reg.rdata;
    assign overflow_flag_zero = state_reg.flag[0];
    assign overflow_flag_one = state_reg.flag[1];

    ////////////////////////////////////////////////////////////////////////////
    // checks on timer zero; timer one runs the same code
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic enabled0;
    assign cnt0 = {state_reg.cnt_hi[0], state_reg.cnt_lo[0]};
    assign cnt1 = {state_reg.cnt_hi[1], state_reg.cnt_lo[1]};
    assign enabled0 = state_reg.run[0]
        && (!state_reg.timer_mode[GATE_BIT] || state_reg.gate_sync[0]);

    run_hold_a: assert property (
        !state_reg.run[0] && !sfr_wr |=> $stable(cnt0))
        else $error("timer zero counted while stopped");

    gate_hold_a: assert property (
        state_reg.timer_mode[GATE_BIT] && !state_reg.gate_sync[0] && !sfr_wr |=> $stable(cnt0))
        else $error("timer zero counted with gate pin low");

    timer_step_a: assert property (
        state_reg.timer_mode[3:0] == 4'h1 && state_reg.run[0] && tick && cnt0 != 16'hffff
        && !sfr_wr |=> cnt0 == $past(cnt0) + 16'h0001)
        else $error("timer zero missed a prescaled step");

    edge_count_a: assert property (
        state_reg.timer_mode[3:0] == 4'h5 && enabled0 && edge_seen[0] && cnt0 != 16'hffff
        && !sfr_wr |=> cnt0 == $past(cnt0) + 16'h0001)
        else $error("falling edge not counted in next cycle");

    no_edge_a: assert property (
        state_reg.timer_mode[2] && !edge_seen[0] && !sfr_wr |=> $stable(cnt0))
        else $error("counter advanced without a falling edge");

    edge_rate_a: assert property (
        edge_seen[0] |=> !edge_seen[0])
        else $error("two edges seen in adjacent cycles");

    reload16_a: assert property (
        step[0] && state_reg.timer_mode[1:0] == 2'b01 && cnt0 == 16'hffff && !sfr_wr
        |=> cnt0 == {state_reg.rel_hi[0], state_reg.rel_lo[0]} && overflow_flag_zero)
        else $error("mode 1 overflow did not reload and flag");

    reload8_a: assert property (
        step[0] && state_reg.timer_mode[1:0] == 2'b10 && state_reg.cnt_lo[0] == 8'hff && !sfr_wr
        |=> state_reg.cnt_lo[0] == $past(state_reg.cnt_hi[0])
        && $stable(state_reg.cnt_hi[0]) && overflow_flag_zero)
        else $error("mode 2 overflow did not reload low byte");

    mode0_ovf_a: assert property (
        ovf[0] && state_reg.timer_mode[1:0] == 2'b00 && !sfr_wr
        |=> state_reg.cnt_hi[0] == 8'h00 && overflow_flag_zero)
        else $error("mode 0 rollover did not set flag");

    stop_mode_a: assert property (
        state_reg.timer_mode[1:0] == 2'b11 && !sfr_wr |=> $stable(cnt0))
        else $error("mode 3 timer kept counting");

    ack_clear_a: assert property (
        int_ack_zero && !ovf[0] && !sfr_wr |=> !overflow_flag_zero)
        else $error("acknowledge did not clear flag");

    flag_set_wins_a: assert property (
        ovf[0] |=> overflow_flag_zero)
        else $error("timer zero overflow lost to a clear");

    // timer one spot checks: a slip in the shared loop index would show only here
    run_one_hold_a: assert property (
        !state_reg.run[1] && !sfr_wr |=> $stable(cnt1))
        else $error("timer one counted while stopped");

    gate_one_hold_a: assert property (
        state_reg.timer_mode[7] && !state_reg.gate_sync[1] && !sfr_wr |=> $stable(cnt1))
        else $error("timer one counted with gate pin low");

    step_one_a: assert property (
        state_reg.timer_mode[7:4] == 4'h1 && state_reg.run[1] && tick && cnt1 != 16'hffff
        && !sfr_wr |=> cnt1 == $past(cnt1) + 16'h0001)
        else $error("timer one missed a prescaled step");

    edge_one_a: assert property (
        state_reg.timer_mode[7:4] == 4'h5 && state_reg.run[1] && edge_seen[1] && cnt1 != 16'hffff
        && !sfr_wr |=> cnt1 == $past(cnt1) + 16'h0001)
        else $error("timer one missed a falling edge");

    ack_one_clear_a: assert property (
        int_ack_one && !ovf[1] && !sfr_wr |=> !overflow_flag_one)
        else $error("acknowledge did not clear timer one flag");

    flag_one_set_a: assert property (
        ovf[1] |=> overflow_flag_one)
        else $error("timer one overflow lost to a clear");

    // default 13-bit layout: the three upper low bits are never touched by counting
    mode0_upper_a: assert property (
        state_reg.timer_mode[1:0] == 2'h0 && state_reg.ext_mode[2:0] == 3'h4 && !sfr_wr
        |=> $stable(state_reg.cnt_lo[0][7:5]))
        else $error("mode 0 count disturbed upper low bits");

    edge_counted_c: cover property (state_reg.timer_mode[2] && step[0]);
    reload16_c: cover property (ovf[0] && state_reg.timer_mode[1:0] == 2'b01);
    reload8_c: cover property (ovf[0] && state_reg.timer_mode[1:0] == 2'b10);
    mode0_c: cover property (ovf[1] && state_reg.timer_mode[5:4] == 2'b00);

endmodule

// File: pulse_source.sv
`timescale 1ns/10ps
// far-side pulse source for one count pin: idles high, sends falling edges on request
module pulse_source (
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] num_pulses,
    output logic pin,
    output logic busy
);
    logic [8:0] left_reg;

    initial begin
        pin = 1'b1;
        left_reg = 9'h000;
    end

    // each level stands one full clock: the fastest rate the counter must follow
    always @(posedge clk) begin
        if (start && left_reg == 9'h000) begin
            left_reg <= {num_pulses, 1'b0};
        end else if (left_reg != 9'h000) begin
            pin <= ~pin;
            left_reg <= left_reg - 9'h001;
        end
    end

    assign busy = (left_reg != 9'h000);
endmodule

// File: dual_reload_timer_counter_test.sv
`timescale 1ns/10ps
module dual_reload_timer_counter_test
    import timer_pkg::*;
;
    logic clk, srst, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, npulse, d;
    logic [TPS_WIDTH-1:0] clock_prescale_value;
    logic [1:0] acks, gates, go, busy, pins;
    logic overflow_flag_zero, overflow_flag_one;
    wire [1:0] flags = {overflow_flag_one, overflow_flag_zero};
    logic [31:0] seed, v, p;
    logic [7:0] ra [9] = '{8'h88, 8'h89, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h8a, 8'h90};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int num_errors, samples_checked, cycles, n, m, t;
    int val [2];

    dual_reload_timer_counter i_dut (
        .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .clock_prescale_value(clock_prescale_value),
        .int_ack_zero(acks[0]), .int_ack_one(acks[1]),
        .count_input_pin_zero(pins[0]), .count_input_pin_one(pins[1]),
        .ext_interrupt_pin_zero(gates[0]), .ext_interrupt_pin_one(gates[1]),
        .sfr_rdata(sfr_rdata), .overflow_flag_zero(overflow_flag_zero),
        .overflow_flag_one(overflow_flag_one));
    pulse_source i_src0 (.clk(clk), .start(go[0]), .num_pulses(npulse), .pin(pins[0]),
        .busy(busy[0]));
    pulse_source i_src1 (.clk(clk), .start(go[1]), .num_pulses(npulse), .pin(pins[1]),
        .busy(busy[1]));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // a hang shows up as a mismatch rather than a silent stall
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // overflow period in clocks for mode, width or reload value, and prescale
    function automatic int exp_period(input int md, input int vl, input int ps);
        if (md == 0) return 256 * (2 ** (vl + 1)) * (ps + 1);
        if (md == 1) return (65536 - vl) * (ps + 1);
        return (256 - vl) * (ps + 1);
    endfunction

    task automatic roll(output logic [31:0] r);
        seed = lfsr_next(lfsr_next(lfsr_next(seed)));
        r = seed;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= wd;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // read data is registered at the edge that takes the strobe and is settled just after it
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] rd);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 rd = sfr_rdata;
    endtask

    task automatic pulse(input int ti, input logic [7:0] cnt);
        int g;
        g = 0;
        @(posedge clk);
        npulse <= cnt;
        go[ti] <= 1'b1;
        @(posedge clk);
        go[ti] <= 1'b0;
        #1;
        while (busy[ti] === 1'b1 && g < 1000) begin
            @(posedge clk);
            #1 g++;
        end
        repeat (6) @(posedge clk);
    endtask

    // first interval is discarded: a stale flag or odd start count would skew it
    task automatic period(input int ti, output int cnt);
        int g, k;
        g = 0;
        while (flags[ti] !== 1'b1 && g < 40000) begin
            @(posedge clk);
            #1 g++;
        end
        for (k = 0; k < 2; k++) begin
            cnt = 0;
            do begin
                @(posedge clk);
                cnt++;
                if (cnt == 1) acks[ti] <= 1'b1;
                if (cnt == 2) acks[ti] <= 1'b0;
                #1;
            // the acknowledge lands at the second edge, so a flag seen there is a new overflow
            end while (cnt < 40000 && !(cnt > 1 && flags[ti] === 1'b1));
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, npulse} = '0;
        {clock_prescale_value, acks, gates, go} = '0;
        {num_errors, samples_checked, cycles} = '0;
        seed = 32'h7ffb;
        srst = 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // reset values, with an unmapped address last
        for (int i = 0; i < 9; i++) begin
            sfr_read(ra[i], d);
            check(d, rv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            roll(v);
            sfr_write(ADDR_RELOAD_LOW_ZERO + i, v[7:0]);
            sfr_read(ADDR_RELOAD_LOW_ZERO + i, d);
            check(d, v[7:0]);
        end
        // counter function, mode 1, both pins at full rate
        sfr_write(ADDR_TIMER_MODE, 8'h55);
        sfr_write(ADDR_TIMER_CONTROL, 8'h50);
        for (t = 0; t < 2; t++) begin
            roll(v);
            pulse(t, v[3:0] + 8'h01);
            sfr_read(ADDR_COUNT_LOW_ZERO + t, d);
            check(d, v[3:0] + 8'h01);
        end
        // gate bit with gate pin low blocks; run bit set keeps the count
        sfr_write(ADDR_TIMER_MODE, 8'hdd);
        for (t = 0; t < 2; t++) begin
            roll(v);
            sfr_write(ADDR_TIMER_CONTROL, 8'h00);
            sfr_write(ADDR_COUNT_LOW_ZERO + t, v[7:0] & 8'h7f);
            sfr_write(ADDR_TIMER_CONTROL, 8'h50);
            pulse(t, 8'h05);
            sfr_read(ADDR_COUNT_LOW_ZERO + t, d);
            check(d, v[7:0] & 8'h7f);
            gates[t] <= 1'b1;
            pulse(t, 8'h03);
            sfr_read(ADDR_COUNT_LOW_ZERO + t, d);
            val[t] = (v[7:0] & 8'h7f) + 3;
            check(d, val[t]);
        end
        // mode 11 holds the count
        sfr_write(ADDR_TIMER_MODE, 8'h77);
        for (t = 0; t < 2; t++) begin
            pulse(t, 8'h04);
            sfr_read(ADDR_COUNT_LOW_ZERO + t, d);
            check(d, val[t]);
        end
        // reload modes: period from reload value or high byte, random prescale
        for (m = 1; m < 3; m++) begin
            roll(p);
            sfr_write(ADDR_TIMER_CONTROL, 8'h00);
            clock_prescale_value <= p[3:0];
            sfr_write(ADDR_TIMER_MODE, (m == 1) ? 8'h11 : 8'h22);
            for (t = 0; t < 2; t++) begin
                roll(v);
                // an all-ones reload overflows on every step, faster than the ack can time
                d = (v[7:0] | 8'h80) & 8'hfe;
                sfr_write(ADDR_RELOAD_LOW_ZERO + t, d);
                sfr_write(ADDR_RELOAD_HIGH_ZERO + t, 8'hff);
                // mode 1 starts near the top so the first overflow comes quickly
                sfr_write(ADDR_COUNT_HIGH_ZERO + t, (m == 1) ? 8'hff : d);
                val[t] = (m == 1) ? {8'hff, d} : d;
            end
            sfr_write(ADDR_TIMER_CONTROL, 8'h50);
            for (t = 0; t < 2; t++) begin
                period(t, n);
                check(n, exp_period(m, val[t], p[3:0]));
            end
            if (m == 2) begin
                sfr_read(ADDR_COUNT_HIGH_ZERO + 1, d);
                check(d, val[1]);
            end
        end
        // mode 0 with prescale widths 1 and 2 bits
        roll(p);
        sfr_write(ADDR_TIMER_CONTROL, 8'h00);
        clock_prescale_value <= {2'b00, p[1:0]};
        sfr_write(ADDR_EXTENDED_TIMER_MODE, 8'h08);
        sfr_write(ADDR_TIMER_MODE, 8'h00);
        sfr_write(ADDR_TIMER_CONTROL, 8'h50);
        for (t = 0; t < 2; t++) begin
            period(t, n);
            check(n, exp_period(0, t, p[1:0]));
        end
        tally_and_finish();
    end
endmodule
